// >>> hw/smc_params.svh
// constants for the sleep mode controller
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_ADDR_CTRL 8'h00
`define SMC_ADDR_AUX 8'h04
`define SMC_ADDR_STAT 8'h08
`define SMC_ADDR_FUSE 8'h0c
`define SMC_SE_BIT 7
`define SMC_SM_HI 6
`define SMC_SM_LO 4
`define SMC_ACD_BIT 0
`define SMC_AS2_BIT 1
`define SMC_CTRL_RST 8'h00
`define SMC_AUX_RST 8'h00
`define SMC_HALT_EXTRA 4
`define SMC_STBY_WAKE 6
`define SMC_STARTUP_CK 6
`define SMC_CNT_W 8
`define SMC_CLOCK_SELECT_FUSES_EXT 4'h0
`define SMC_CLOCK_SELECT_FUSES_RC_LO 4'h1
`define SMC_CLOCK_SELECT_FUSES_RC_HI 4'h4
`endif

// >>> hw/smc_pkg.sv
// types for the sleep mode controller
`default_nettype none
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_M_IDLE = 3'h0,
      SMC_M_QUIET = 3'h1,
      SMC_M_PDOWN = 3'h2,
      SMC_M_PSAVE = 3'h3,
      SMC_M_RSV4 = 3'h4,
      SMC_M_RSV5 = 3'h5,
      SMC_M_STBY = 3'h6,
      SMC_M_XSTBY = 3'h7
   } smc_mode_e;
   typedef enum logic [1:0] {
      SMC_S_RUN = 2'h0,
      SMC_S_SLEEP = 2'h1,
      SMC_S_WAKE = 2'h2
   } smc_state_e;
   typedef struct packed {
      logic core;
      logic flash;
      logic io;
      logic adc;
      logic asy;
      logic osc;
   } smc_clk_s;
   typedef struct packed {
      logic ext_edge;
      logic ext_level;
      logic twi_match;
      logic timer2;
      logic spm_ready;
      logic adc_done;
      logic comparator;
      logic other_io;
   } smc_wake_s;
endpackage
`default_nettype wire

// >>> hw/smc_sync.sv
// two flip-flop synchroniser for a vector of levels
`default_nettype none
module smc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> hw/smc_top.sv
// sleep mode controller with AHB-Lite register slave
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "smc_params.svh"
`default_nettype none
module smc_top #(
   parameter int CNT_W = `SMC_CNT_W
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // core side
   input wire logic sleep_instr,
   input wire logic [3:0] clock_select_fuses,
   input wire logic adc_enabled,
   output logic core_halt,
   output logic irq_resume,
   // wake sources, asynchronous
   input wire smc_pkg::smc_wake_s wake_in,
   // clock gates and converter start
   output smc_pkg::smc_clk_s clk_en,
   output logic comparator_power,
   output logic adc_start
);
   localparam logic [CNT_W-1:0] HALT_N = CNT_W'(`SMC_HALT_EXTRA);
   localparam logic [CNT_W-1:0] STBY_N = CNT_W'(`SMC_STBY_WAKE);
   localparam logic [CNT_W-1:0] SUT_N = CNT_W'(`SMC_STARTUP_CK);

   smc_pkg::smc_state_e state_reg;
   smc_pkg::smc_mode_e mode_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] aux_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [7:0] wake_sync;
   smc_pkg::smc_wake_s ws;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic sleep_ok;
   logic wake_hit;
   logic [2:0] mode_sel;
   logic crystal;

   smc_sync #(.W(8)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(wake_in),
      .q(wake_sync)
   );
   assign ws = smc_pkg::smc_wake_s'(wake_sync);

   function automatic logic is_xtal(input logic [3:0] ck);
      is_xtal = (ck != `SMC_CLOCK_SELECT_FUSES_EXT) &&
         !(ck >= `SMC_CLOCK_SELECT_FUSES_RC_LO && ck <= `SMC_CLOCK_SELECT_FUSES_RC_HI);
   endfunction

   // per-mode qualified wake
   function automatic logic wake_ok(input smc_pkg::smc_mode_e m,
      input smc_pkg::smc_wake_s w, input logic acd, input logic as2);
      logic base;
      base = w.ext_level || w.twi_match;
      case (m)
         smc_pkg::SMC_M_IDLE: wake_ok = (|w[7:2]) || w.other_io ||
            (w.comparator && !acd);
         smc_pkg::SMC_M_QUIET: wake_ok = base || w.timer2 || w.spm_ready ||
            w.adc_done;
         smc_pkg::SMC_M_PDOWN: wake_ok = base;
         smc_pkg::SMC_M_STBY: wake_ok = base;
         smc_pkg::SMC_M_PSAVE: wake_ok = base || (w.timer2 && as2);
         smc_pkg::SMC_M_XSTBY: wake_ok = base || (w.timer2 && as2);
         default: wake_ok = 1'b0;
      endcase
   endfunction

   assign mode_sel = ctrl_reg[`SMC_SM_HI:`SMC_SM_LO];
   assign crystal = is_xtal(clock_select_fuses);
   // reserved codes and standby without crystal never sleep
   assign sleep_ok = sleep_instr && ctrl_reg[`SMC_SE_BIT] &&
      mode_sel != 3'h4 && mode_sel != 3'h5 &&
      (!mode_sel[2] || crystal);
   assign wake_hit = wake_ok(mode_reg, ws, aux_reg[`SMC_ACD_BIT],
      aux_reg[`SMC_AS2_BIT]);

   // bus address phase capture; zero wait state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         wr_addr_reg <= haddr;
      end
   end

   // control and auxiliary registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= `SMC_CTRL_RST;
         aux_reg <= `SMC_AUX_RST;
      end
      else if (wr_pend_reg)
      begin
         if (wr_addr_reg == `SMC_ADDR_CTRL)
            ctrl_reg <= hwdata[7:0];
         if (wr_addr_reg == `SMC_ADDR_AUX)
            aux_reg <= {6'h00, hwdata[1:0]};
      end
   end

   // read data, registered off the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         case (haddr)
            `SMC_ADDR_CTRL: hrdata <= {24'h000000, ctrl_reg};
            `SMC_ADDR_AUX: hrdata <= {24'h000000, aux_reg};
            `SMC_ADDR_STAT: hrdata <= {27'h0000000, mode_reg, state_reg};
            `SMC_ADDR_FUSE: hrdata <= {27'h0000000, crystal,
               clock_select_fuses};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // sleep state machine; reset returns state to run, mode to idle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= smc_pkg::SMC_S_RUN;
         mode_reg <= smc_pkg::SMC_M_IDLE;
         cnt_reg <= '0;
      end
      else
      begin
         case (state_reg)
            smc_pkg::SMC_S_RUN:
            begin
               if (sleep_ok)
               begin
                  state_reg <= smc_pkg::SMC_S_SLEEP;
                  mode_reg <= smc_pkg::smc_mode_e'(mode_sel);
               end
            end
            smc_pkg::SMC_S_SLEEP:
            begin
               if (wake_hit)
               begin
                  state_reg <= smc_pkg::SMC_S_WAKE;
                  case (mode_reg)
                     smc_pkg::SMC_M_PDOWN, smc_pkg::SMC_M_PSAVE:
                        cnt_reg <= CNT_W'(SUT_N + HALT_N);
                     smc_pkg::SMC_M_STBY, smc_pkg::SMC_M_XSTBY:
                        cnt_reg <= CNT_W'(STBY_N + HALT_N);
                     default: cnt_reg <= HALT_N;
                  endcase
               end
            end
            smc_pkg::SMC_S_WAKE:
            begin
               cnt_reg <= cnt_reg - 1'b1;
               if (cnt_reg == CNT_W'(1))
                  state_reg <= smc_pkg::SMC_S_RUN;
            end
            default: state_reg <= smc_pkg::SMC_S_RUN;
         endcase
      end
   end

   // clock gates per mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_en <= '1;
         comparator_power <= 1'b1;
      end
      else if (state_reg == smc_pkg::SMC_S_SLEEP)
      begin
         comparator_power <= (mode_reg == smc_pkg::SMC_M_IDLE) &&
            !aux_reg[`SMC_ACD_BIT];
         case (mode_reg)
            smc_pkg::SMC_M_IDLE: clk_en <= 6'b001111;
            smc_pkg::SMC_M_QUIET: clk_en <= 6'b000111;
            smc_pkg::SMC_M_PDOWN: clk_en <= 6'b000000;
            smc_pkg::SMC_M_PSAVE:
               clk_en <= {4'h0, aux_reg[`SMC_AS2_BIT], 1'b0};
            smc_pkg::SMC_M_STBY: clk_en <= 6'b000001;
            smc_pkg::SMC_M_XSTBY:
               clk_en <= {4'h0, aux_reg[`SMC_AS2_BIT], 1'b1};
            default: clk_en <= '1;
         endcase
      end
      else if (state_reg == smc_pkg::SMC_S_WAKE)
      begin
         clk_en <= 6'b011111;
         clk_en.core <= 1'b0;
         comparator_power <= 1'b1;
      end
      else
      begin
         clk_en <= '1;
         comparator_power <= 1'b1;
      end
   end

   // core halt, resume pulse, converter start
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         core_halt <= 1'b0;
         irq_resume <= 1'b0;
         adc_start <= 1'b0;
      end
      else
      begin
         core_halt <= (state_reg == smc_pkg::SMC_S_RUN) ? sleep_ok :
            !(state_reg == smc_pkg::SMC_S_WAKE && cnt_reg == CNT_W'(1));
         irq_resume <= state_reg == smc_pkg::SMC_S_WAKE &&
            cnt_reg == CNT_W'(1);
         adc_start <= state_reg == smc_pkg::SMC_S_RUN && sleep_ok &&
            adc_enabled && !mode_sel[2] && !mode_sel[1];
      end
   end

   AST_NO_SLEEP_WITHOUT_SE: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_RUN && !ctrl_reg[`SMC_SE_BIT])
      |=> state_reg != smc_pkg::SMC_S_SLEEP)
      else $error("sleep entered without enable");
   AST_RESERVED_NOP: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_RUN && mode_sel[2:1] == 2'b10)
      |=> state_reg == smc_pkg::SMC_S_RUN)
      else $error("reserved mode slept");
   AST_STBY_XTAL: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_RUN && mode_sel[2] && !crystal)
      |=> state_reg == smc_pkg::SMC_S_RUN)
      else $error("standby without crystal");
   AST_IDLE_HALT_LEN: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_SLEEP && wake_hit &&
      mode_reg == smc_pkg::SMC_M_IDLE) |=> ##3 irq_resume == 1'b0 ##1
      irq_resume)
      else $error("idle wake halt not four cycles");
   AST_STBY_WAKE: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_SLEEP && wake_hit &&
      mode_reg == smc_pkg::SMC_M_STBY) |=> !irq_resume [*8] ##1
      !irq_resume [*2] ##1 irq_resume)
      else $error("standby wake not six plus four");
   AST_PDOWN_CLOCKS: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ($past(state_reg) == smc_pkg::SMC_S_SLEEP &&
      $past(mode_reg) == smc_pkg::SMC_M_PDOWN) |-> clk_en == '0)
      else $error("power-off clocks running");
   AST_IDLE_CLOCKS: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ($past(state_reg) == smc_pkg::SMC_S_SLEEP &&
      $past(mode_reg) == smc_pkg::SMC_M_IDLE) |->
      !clk_en.core && !clk_en.flash && clk_en.io && clk_en.osc)
      else $error("idle clock gating wrong");
   AST_PDOWN_NO_TIMER: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_SLEEP && mode_reg ==
      smc_pkg::SMC_M_PDOWN && !ws.ext_level && !ws.twi_match)
      |=> state_reg == smc_pkg::SMC_S_SLEEP)
      else $error("power-off woke on wrong source");
   AST_ADC_START: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (state_reg == smc_pkg::SMC_S_RUN && sleep_ok && adc_enabled &&
      mode_sel == 3'h1) |=> adc_start)
      else $error("conversion not started");
   AST_ACD_IDLE: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ($past(state_reg) == smc_pkg::SMC_S_SLEEP &&
      $past(aux_reg[`SMC_ACD_BIT])) |-> !comparator_power)
      else $error("comparator powered");
   COV_IDLE: cover property (@(posedge hclk) disable iff (!hresetn)
      mode_reg == smc_pkg::SMC_M_IDLE && irq_resume);
   COV_PDOWN: cover property (@(posedge hclk) disable iff (!hresetn)
      mode_reg == smc_pkg::SMC_M_PDOWN && irq_resume);
   COV_XSTBY: cover property (@(posedge hclk) disable iff (!hresetn)
      mode_reg == smc_pkg::SMC_M_XSTBY && irq_resume);
endmodule
`default_nettype wire

// >>> dv/smc_core_model.sv
// core-side model: sleep instruction and held wake levels
`default_nettype none
module smc_core_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // controller side
   input wire logic core_halt,
   output var logic sleep_instr,
   output var smc_pkg::smc_wake_s wake_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic halt_q;
   initial
   begin
      sleep_instr = 1'b0;
      wake_in = '0;
   end
   task automatic sleep_now();
      sleep_instr <= 1'b1;
      @(posedge hclk);
      sleep_instr <= 1'b0;
   endtask
   task automatic raise(input logic [7:0] m);
      wake_in <= smc_pkg::smc_wake_s'(m);
   endtask
   // a wake level stays up until the core has been released
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         halt_q <= 1'b0;
      else
      begin
         halt_q <= core_halt;
         if (halt_q && !core_halt)
            wake_in <= '0;
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// testbench for the sleep mode controller
`include "smc_params.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic sleep_instr, adc_enabled, core_halt, irq_resume;
   logic comparator_power, adc_start;
   logic [3:0] clock_select_fuses;
   smc_pkg::smc_wake_s wake_in;
   smc_pkg::smc_clk_s clk_en;
   int n_fail, n_compared, n_adc, lat, lat0;
   // mode, gated clocks, waking and non-waking source, extra wake cycles
   localparam logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
   localparam logic [5:0] ck [6] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h01,
      6'h03};
   localparam logic [7:0] gw [6] = '{8'h01, 8'h04, 8'h20, 8'h10, 8'h40,
      8'h10};
   localparam logic [7:0] bw [6] = '{8'h02, 8'h01, 8'h10, 8'h04, 8'h08,
      8'h01};
   localparam int dl [6] = '{0, 0, `SMC_STARTUP_CK, `SMC_STARTUP_CK,
      `SMC_STBY_WAKE, `SMC_STBY_WAKE};
   // fuse setting and control value that must not sleep
   localparam logic [11:0] noop [4] = '{12'h800, 12'h8c0, 12'h8d0, 12'h1e0};
   assign hready = hreadyout;
   always #2.5 hclk = ~hclk;
   always @(posedge hclk)
      if (adc_start === 1'b1)
         n_adc++;
   smc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sleep_instr(sleep_instr),
      .clock_select_fuses(clock_select_fuses), .adc_enabled(adc_enabled),
      .core_halt(core_halt), .irq_resume(irq_resume), .wake_in(wake_in),
      .clk_en(clk_en), .comparator_power(comparator_power),
      .adc_start(adc_start));
   smc_core_model u_core (.hclk(hclk), .hresetn(hresetn),
      .core_halt(core_halt), .sleep_instr(sleep_instr), .wake_in(wake_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
         n_fail++;
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one single-word transfer; address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rdat = hrdata;
   endtask
   task automatic run_mode(input int i);
      int a0;
      a0 = n_adc;
      adc_enabled <= (i != 0);
      bus(1'b1, `SMC_ADDR_CTRL, {24'h0, 1'b1, md[i], 4'h0}, rd);
      u_core.sleep_now();
      repeat (3) @(posedge hclk);
      check(32'(core_halt), 32'h1);
      check(32'(clk_en), 32'(ck[i]));
      check(32'(n_adc - a0), 32'(md[i] < 3'h2 && i != 0));
      bus(1'b0, `SMC_ADDR_STAT, 32'h0, rd);
      check(rd, {27'h0, md[i], 2'h1});
      if (i == 0)
         check(32'(comparator_power), 32'h0);
      u_core.raise(bw[i]);
      repeat (20) @(posedge hclk);
      check(32'(core_halt), 32'h1);
      u_core.raise(8'h00);
      repeat (5) @(posedge hclk);
      u_core.raise(gw[i]);
      lat = 0;
      while (irq_resume !== 1'b1 && lat < 200)
      begin
         @(posedge hclk);
         lat++;
      end
      if (i == 0)
         lat0 = lat;
      check(32'(core_halt), 32'h0);
      check(32'(lat >= `SMC_HALT_EXTRA), 32'h1);
      check(32'(lat - lat0), 32'(dl[i]));
      bus(1'b1, `SMC_ADDR_CTRL, 32'h0, rd);
      $display("test mode %0d done", md[i]);
   endtask
   initial
   begin
      repeat (5000) @(posedge hclk);
      n_fail++;
      $display("watchdog expired");
      summarize();
   end
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
      clock_select_fuses = 4'h8;
      adc_enabled = 1'b1;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b0, `SMC_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'(`SMC_CTRL_RST));
      check(32'(hresp), 32'h0);
      bus(1'b1, `SMC_ADDR_CTRL, 32'hf0, rd);
      bus(1'b0, `SMC_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'hf0);
      bus(1'b0, `SMC_ADDR_AUX, 32'h0, rd);
      check(rd, 32'(`SMC_AUX_RST));
      bus(1'b1, 8'h10, 32'hff, rd);
      bus(1'b0, 8'h10, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b0, `SMC_ADDR_FUSE, 32'h0, rd);
      check(rd, 32'h18);
      bus(1'b1, `SMC_ADDR_AUX, 32'h3, rd);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         clock_select_fuses <= noop[i][11:8];
         bus(1'b1, `SMC_ADDR_CTRL, {24'h0, noop[i][7:0]}, rd);
         u_core.sleep_now();
         repeat (3) @(posedge hclk);
         check(32'(core_halt), 32'h0);
         check(32'(clk_en), 32'h3f);
      end
      clock_select_fuses <= 4'h8;
      $display("test no-operation sleep done");
      for (int i = 0; i < 6; i++)
         run_mode(i);
      bus(1'b1, `SMC_ADDR_CTRL, 32'ha0, rd);
      u_core.sleep_now();
      repeat (3) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      check(32'(core_halt), 32'h0);
      check(32'(clk_en), 32'h3f);
      bus(1'b0, `SMC_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h0);
      $display("test reset in sleep done");
      summarize();
   end
endmodule
`default_nettype wire
